/* rtl/tmon_pkg.sv */
// Purpose: Shared constants and types of the temperature register bank and duty slew logic
// Assumes: 100 MHz mclk, register port already decoded from the management bus
// Notes: All offsets, reset values and timing counts live here
`default_nettype none
package tmon_pkg;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h06;
  localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_REMOTE_HIGH = 8'h0B;
  localparam logic [7:0] ADDR_LOCAL_UPPER = 8'h14;
  localparam logic [7:0] ADDR_LOCAL_LOWER = 8'h15;
  localparam logic [7:0] ADDR_LOCAL_THERM = 8'h16;
  localparam logic [7:0] ADDR_REMOTE_UPPER = 8'h18;
  localparam logic [7:0] ADDR_REMOTE_LOWER = 8'h19;
  localparam logic [7:0] ADDR_REMOTE_THERM = 8'h1A;

  localparam logic [7:0] RST_TEMP_LOW = 8'h00;
  localparam logic [7:0] RST_TEMP_HIGH = 8'h80;
  localparam logic [7:0] RST_LOCAL_UPPER = 8'h3C;
  localparam logic [7:0] RST_LOCAL_LOWER = 8'h00;
  localparam logic [7:0] RST_LOCAL_THERM = 8'h46;
  localparam logic [7:0] RST_REMOTE_UPPER = 8'h50;
  localparam logic [7:0] RST_REMOTE_LOWER = 8'h00;
  localparam logic [7:0] RST_REMOTE_THERM = 8'h64;
  localparam logic [7:0] RST_DUTY = 8'h00;

  // Low-byte layout: local LSBs at 7:5, remote LSBs at 2:0
  localparam int LOW_LOCAL_POS = 5;
  localparam int LOW_REMOTE_POS = 0;
  localparam int TEMP_W = 11;
  localparam int LIMIT_LSB_ZEROS = 3;

  localparam logic [15:0] RPM_DEADBAND = 16'h000A;

  // Base tick of the slew logic is 8 Hz, the fastest documented update rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_TICK_NS = 125_000_000;
  localparam int BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam int RATE_SUB_W = 7;
  localparam int RPM_SLOW_SHIFT = 3;

  typedef enum logic [2:0] {
    MODE_AUTO = 3'b001,
    MODE_RPM = 3'b010,
    MODE_DCY = 3'b100
  } tmon_mode_t;

  typedef struct packed {
    logic ramp_enable;
    logic [1:0] duty_step_size;
    logic [2:0] duty_update_rate;
    logic [1:0] duty_adjust_threshold;
    logic fast_speed_monitor;
  } tmon_slew_cfg_t;

  typedef struct packed {
    logic [7:0] local_upper_bound_value;
    logic [7:0] local_lower_bound_value;
    logic [7:0] local_thermal_value;
    logic [7:0] remote_upper_bound_value;
    logic [7:0] remote_lower_bound_value;
    logic [7:0] remote_thermal_value;
  } tmon_limits_t;

  typedef struct packed {
    logic local_high;
    logic local_low;
    logic local_therm;
    logic remote_high;
    logic remote_low;
    logic remote_therm;
  } tmon_flags_t;
endpackage
`default_nettype wire

/* rtl/tmon_rate_gen.sv */
// Purpose: Update-tick generator for the duty slew logic
// Assumes: One clock; ticks are one-cycle enables
// Notes: Auto rates are the 8 Hz base tick divided by powers of two from 1 to 128
`default_nettype none
module tmon_rate_gen #(
  parameter int TICK_CYCLES = tmon_pkg::BASE_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [2:0] duty_update_rate,
  input wire logic fast_speed_monitor,
  output logic auto_tick,
  output logic rpm_tick
);
  localparam int CW = $clog2(TICK_CYCLES);
  localparam int SW = tmon_pkg::RATE_SUB_W;

  if (TICK_CYCLES < 2) begin : g_bad
    $error("TICK_CYCLES must be at least 2");
  end

  logic [CW-1:0] base_q, base_d;
  logic [SW-1:0] sub_q, sub_d;
  logic base_tick;
  logic [SW-1:0] mask;

  always_comb begin
    base_tick = (base_q == CW'(TICK_CYCLES - 1));
    base_d = base_tick ? '0 : base_q + CW'(1);
    sub_d = base_tick ? sub_q + SW'(1) : sub_q;
    // Code 7 keeps every base tick, code 0 one in 128
    mask = SW'((8'd1 << (3'd7 - duty_update_rate)) - 8'd1);
    auto_tick = base_tick && ((sub_q & mask) == '0);
    rpm_tick = base_tick && (fast_speed_monitor ||
      (sub_q[tmon_pkg::RPM_SLOW_SHIFT-1:0] == '0));
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= '0;
      sub_q <= '0;
    end else begin
      base_q <= base_d;
      sub_q <= sub_d;
    end
  end
endmodule
`default_nettype wire

/* rtl/tmon_regs_slew.sv */
// Purpose: Temperature register bank with read freeze, limit registers, duty slew logic
// Assumes: Register port already decoded from the management bus; all inputs on mclk
// Notes: Read data appear one cycle after the read strobe
`default_nettype none
// Functional notes
// - Software-RPM mode always ramps, ramp enable is ignored.
// - Software-RPM mode changes duty by the step each update, or by the smaller room left below 0xFF or above 0x00.
// - Auto mode: step caps change only with ramp on; code 00 is one unit.
// - A remaining change smaller than the step is applied exactly.
// - Auto mode rate code sets updates per second, 111 is 8, 100 is 1.
// - Update rate never slows temperature sampling.
// - Software-RPM update rate comes from the fast speed-monitor bit.
// - Auto mode skips changes not larger than the threshold code plus one.
// - Software-RPM stops adjusting when period error is at most 0x000A.
// - Duty cycle is held as 8 bits, 1/256 per unit.
// - Low byte holds local LSBs at 7:5, remote LSBs at 2:0, 4:3 zero.
// - High bytes at 0x0A and 0x0B hold eight MSBs, reset to 0x80.
// - Reading 0x06 freezes readings until 0x0B is read.
// - Limits are 11-bit with three zero LSBs, eight MSBs stored.
// - Local upper and lower bounds at 0x14, 0x15, reset 0x3C, 0x00.
// - Remote upper and lower bounds at 0x18, 0x19, reset 0x50, 0x00.
// - Thermal thresholds at 0x16 and 0x1A, reset 0x46 and 0x64.
// - Direct duty mode ignores the whole adjustment control.
module tmon_regs_slew #(
  parameter int TICK_CYCLES = tmon_pkg::BASE_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic temp_valid,
  input wire logic [10:0] local_temp_reading,
  input wire logic [10:0] remote_temp_reading,
  input wire tmon_pkg::tmon_mode_t fan_mode,
  input wire tmon_pkg::tmon_slew_cfg_t slew_cfg,
  input wire logic [7:0] target_duty,
  input wire logic [7:0] sw_duty,
  input wire logic [15:0] fan_period_count,
  input wire logic [15:0] fan_period_target,
  output logic [7:0] duty_cycle,
  output tmon_pkg::tmon_limits_t limits,
  output tmon_pkg::tmon_flags_t temp_flags
);
  localparam int TW = tmon_pkg::TEMP_W;

  // The tick divider needs at least two cycles per base tick
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  logic auto_tick, rpm_tick;

  tmon_rate_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_rate (
    .mclk(mclk),
    .reset_n(reset_n),
    .duty_update_rate(slew_cfg.duty_update_rate),
    .fast_speed_monitor(slew_cfg.fast_speed_monitor),
    .auto_tick(auto_tick),
    .rpm_tick(rpm_tick)
  );

  // Temperature state: live copies always follow the converter, the visible
  // copies follow the live ones unless frozen by a low-byte read
  logic [TW-1:0] loc_live_q, loc_live_d, rem_live_q, rem_live_d;
  logic [TW-1:0] loc_vis_q, loc_vis_d, rem_vis_q, rem_vis_d;
  logic frozen_q, frozen_d;
  logic rd_low, rd_rem_high;

  always_comb begin
    rd_low = reg_rd && (reg_addr == tmon_pkg::ADDR_TEMP_LOW);
    rd_rem_high = reg_rd && (reg_addr == tmon_pkg::ADDR_REMOTE_HIGH);
    loc_live_d = temp_valid ? local_temp_reading : loc_live_q;
    rem_live_d = temp_valid ? remote_temp_reading : rem_live_q;
    // Set wins: a low-byte read always starts a fresh freeze
    frozen_d = rd_low ? 1'b1 : (rd_rem_high ? 1'b0 : frozen_q);
    loc_vis_d = (frozen_q || rd_low) ? loc_vis_q : loc_live_q;
    rem_vis_d = (frozen_q || rd_low) ? rem_vis_q : rem_live_q;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loc_live_q <= {tmon_pkg::RST_TEMP_HIGH, 3'b000};
      rem_live_q <= {tmon_pkg::RST_TEMP_HIGH, 3'b000};
      loc_vis_q <= {tmon_pkg::RST_TEMP_HIGH, 3'b000};
      rem_vis_q <= {tmon_pkg::RST_TEMP_HIGH, 3'b000};
      frozen_q <= 1'b0;
    end else begin
      loc_live_q <= loc_live_d;
      rem_live_q <= rem_live_d;
      loc_vis_q <= loc_vis_d;
      rem_vis_q <= rem_vis_d;
      frozen_q <= frozen_d;
    end
  end

  // Limit registers
  tmon_pkg::tmon_limits_t lim_q, lim_d;
  tmon_pkg::tmon_flags_t flags_q, flags_d;
  logic signed [TW-1:0] loc_s, rem_s;

  always_comb begin
    lim_d = lim_q;
    if (reg_wr) begin
      unique case (reg_addr)
        tmon_pkg::ADDR_LOCAL_UPPER: lim_d.local_upper_bound_value = reg_wdata;
        tmon_pkg::ADDR_LOCAL_LOWER: lim_d.local_lower_bound_value = reg_wdata;
        tmon_pkg::ADDR_LOCAL_THERM: lim_d.local_thermal_value = reg_wdata;
        tmon_pkg::ADDR_REMOTE_UPPER: lim_d.remote_upper_bound_value = reg_wdata;
        tmon_pkg::ADDR_REMOTE_LOWER: lim_d.remote_lower_bound_value = reg_wdata;
        tmon_pkg::ADDR_REMOTE_THERM: lim_d.remote_thermal_value = reg_wdata;
        default: lim_d = lim_q;
      endcase
    end
    // Readings are two's complement; limits widen with three zero LSBs
    loc_s = loc_live_q;
    rem_s = rem_live_q;
    flags_d = flags_q;
    if (temp_valid) begin
      flags_d.local_high = loc_s > $signed({lim_q.local_upper_bound_value, 3'b000});
      flags_d.local_low = loc_s < $signed({lim_q.local_lower_bound_value, 3'b000});
      flags_d.local_therm = loc_s > $signed({lim_q.local_thermal_value, 3'b000});
      flags_d.remote_high = rem_s > $signed({lim_q.remote_upper_bound_value, 3'b000});
      flags_d.remote_low = rem_s < $signed({lim_q.remote_lower_bound_value, 3'b000});
      flags_d.remote_therm = rem_s > $signed({lim_q.remote_thermal_value, 3'b000});
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lim_q.local_upper_bound_value <= tmon_pkg::RST_LOCAL_UPPER;
      lim_q.local_lower_bound_value <= tmon_pkg::RST_LOCAL_LOWER;
      lim_q.local_thermal_value <= tmon_pkg::RST_LOCAL_THERM;
      lim_q.remote_upper_bound_value <= tmon_pkg::RST_REMOTE_UPPER;
      lim_q.remote_lower_bound_value <= tmon_pkg::RST_REMOTE_LOWER;
      lim_q.remote_thermal_value <= tmon_pkg::RST_REMOTE_THERM;
      flags_q <= '0;
    end else begin
      lim_q <= lim_d;
      flags_q <= flags_d;
    end
  end

  // Register read path
  logic [7:0] rdata_q, rdata_d, raddr_q;
  logic rvalid_q;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        tmon_pkg::ADDR_TEMP_LOW:
          rdata_d = tmon_pkg::RST_TEMP_LOW |
            (8'(loc_vis_q[2:0]) << tmon_pkg::LOW_LOCAL_POS) |
            (8'(rem_vis_q[2:0]) << tmon_pkg::LOW_REMOTE_POS);
        tmon_pkg::ADDR_LOCAL_HIGH: rdata_d = loc_vis_q[10:3];
        tmon_pkg::ADDR_REMOTE_HIGH: rdata_d = rem_vis_q[10:3];
        tmon_pkg::ADDR_LOCAL_UPPER: rdata_d = lim_q.local_upper_bound_value;
        tmon_pkg::ADDR_LOCAL_LOWER: rdata_d = lim_q.local_lower_bound_value;
        tmon_pkg::ADDR_LOCAL_THERM: rdata_d = lim_q.local_thermal_value;
        tmon_pkg::ADDR_REMOTE_UPPER: rdata_d = lim_q.remote_upper_bound_value;
        tmon_pkg::ADDR_REMOTE_LOWER: rdata_d = lim_q.remote_lower_bound_value;
        tmon_pkg::ADDR_REMOTE_THERM: rdata_d = lim_q.remote_thermal_value;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      raddr_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= reg_rd;
      raddr_q <= reg_rd ? reg_addr : raddr_q;
    end
  end

  // Duty slew
  logic [7:0] duty_q, duty_d;
  logic [8:0] step, thr, diff_a, delta, room;
  logic [15:0] err_r;
  logic up_a, up_r;

  always_comb begin
    step = 9'd1 << slew_cfg.duty_step_size;
    thr = 9'(slew_cfg.duty_adjust_threshold) + 9'd1;
    up_a = target_duty > duty_q;
    diff_a = up_a ? 9'(target_duty - duty_q) : 9'(duty_q - target_duty);
    // Longer period means a slower fan, so the duty must rise
    up_r = fan_period_count > fan_period_target;
    err_r = up_r ? fan_period_count - fan_period_target
                 : fan_period_target - fan_period_count;
    room = up_r ? 9'(8'hFF - duty_q) : 9'(duty_q);
    delta = 9'd0;
    duty_d = duty_q;
    unique case (fan_mode)
      tmon_pkg::MODE_DCY: duty_d = sw_duty;
      tmon_pkg::MODE_AUTO: begin
        if (auto_tick && diff_a > thr) begin
          if (!slew_cfg.ramp_enable) begin
            duty_d = target_duty;
          end else begin
            delta = (diff_a < step) ? diff_a : step;
            duty_d = up_a ? duty_q + delta[7:0] : duty_q - delta[7:0];
          end
        end
      end
      tmon_pkg::MODE_RPM: begin
        // Ramp enable, rate and threshold fields play no part here
        if (rpm_tick && err_r > tmon_pkg::RPM_DEADBAND) begin
          delta = (room < step) ? room : step;
          duty_d = up_r ? duty_q + delta[7:0] : duty_q - delta[7:0];
        end
      end
      default: duty_d = duty_q;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      duty_q <= tmon_pkg::RST_DUTY;
    end else begin
      duty_q <= duty_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign duty_cycle = duty_q;
  assign limits = lim_q;
  assign temp_flags = flags_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_dcy_follows: assert property (
    fan_mode == tmon_pkg::MODE_DCY |=> duty_q == $past(sw_duty))
    else $error("duty does not follow direct value");

  a_auto_dead: assert property (
    fan_mode == tmon_pkg::MODE_AUTO && auto_tick && diff_a <= thr |=> $stable(duty_q))
    else $error("duty moved inside threshold");

  a_auto_jump: assert property (
    fan_mode == tmon_pkg::MODE_AUTO && auto_tick && diff_a > thr && !slew_cfg.ramp_enable
    |=> duty_q == $past(target_duty))
    else $error("no-ramp update missed target");

  a_auto_cap: assert property (
    fan_mode == tmon_pkg::MODE_AUTO && auto_tick && diff_a > thr && slew_cfg.ramp_enable
    && diff_a <= step |=> duty_q == $past(target_duty))
    else $error("short remainder not applied exactly");

  a_auto_step_up: assert property (
    fan_mode == tmon_pkg::MODE_AUTO && auto_tick && diff_a > thr && slew_cfg.ramp_enable
    && diff_a > step && up_a |=> duty_q == $past(duty_q) + $past(step[7:0]))
    else $error("auto ramp up step wrong");

  a_auto_step_dn: assert property (
    fan_mode == tmon_pkg::MODE_AUTO && auto_tick && diff_a > thr && slew_cfg.ramp_enable
    && diff_a > step && !up_a |=> duty_q == $past(duty_q) - $past(step[7:0]))
    else $error("auto ramp down step wrong");

  a_auto_idle: assert property (
    fan_mode == tmon_pkg::MODE_AUTO && !auto_tick |=> $stable(duty_q))
    else $error("auto duty moved between updates");

  a_rpm_step: assert property (
    fan_mode == tmon_pkg::MODE_RPM && rpm_tick && err_r > tmon_pkg::RPM_DEADBAND && up_r
    && room >= step |=> 9'(duty_q - $past(duty_q)) == $past(step))
    else $error("rpm step size wrong");

  a_rpm_step_dn: assert property (
    fan_mode == tmon_pkg::MODE_RPM && rpm_tick && err_r > tmon_pkg::RPM_DEADBAND && !up_r
    && room >= step |=> duty_q == $past(duty_q) - $past(step[7:0]))
    else $error("rpm down step size wrong");

  a_rpm_clamp: assert property (
    fan_mode == tmon_pkg::MODE_RPM && rpm_tick && err_r > tmon_pkg::RPM_DEADBAND
    && room < step |=> duty_q == ($past(up_r) ? 8'hFF : 8'h00))
    else $error("rpm remainder not applied exactly");

  a_rpm_idle: assert property (
    fan_mode == tmon_pkg::MODE_RPM && !rpm_tick |=> $stable(duty_q))
    else $error("rpm duty moved between updates");

  a_rpm_dead: assert property (
    fan_mode == tmon_pkg::MODE_RPM && err_r <= tmon_pkg::RPM_DEADBAND |=> $stable(duty_q))
    else $error("rpm adjusted inside deadband");

  a_low_layout: assert property (
    reg_rvalid && raddr_q == tmon_pkg::ADDR_TEMP_LOW |-> reg_rdata[4:3] == 2'b00)
    else $error("low byte reserved bits set");

  a_low_value: assert property (
    rd_low |=> reg_rdata[7:5] == $past(loc_vis_q[2:0])
    && reg_rdata[2:0] == $past(rem_vis_q[2:0]))
    else $error("low byte fields wrong");

  a_local_rd: assert property (
    reg_rd && reg_addr == tmon_pkg::ADDR_LOCAL_HIGH
    |=> reg_rvalid && reg_rdata == $past(loc_vis_q[10:3]))
    else $error("local high byte wrong");

  a_remote_rd: assert property (
    reg_rd && reg_addr == tmon_pkg::ADDR_REMOTE_HIGH
    |=> reg_rvalid && reg_rdata == $past(rem_vis_q[10:3]))
    else $error("remote high byte wrong");

  a_freeze_set: assert property (
    rd_low |=> frozen_q)
    else $error("low byte read did not freeze");

  a_freeze_release: assert property (
    rd_rem_high |=> !frozen_q)
    else $error("remote high read did not release");

  a_freeze_hold: assert property (
    rd_low ##1 (!rd_rem_high)[*3] |-> $stable(loc_vis_q) && $stable(rem_vis_q))
    else $error("readings changed while frozen");

  a_vis_follows: assert property (
    !frozen_q && !rd_low
    |=> loc_vis_q == $past(loc_live_q) && rem_vis_q == $past(rem_live_q))
    else $error("visible reading not updated");

  a_live_runs: assert property (
    temp_valid && frozen_q |=> loc_live_q == $past(local_temp_reading))
    else $error("live reading stalled by freeze");

  a_limit_wr: assert property (
    reg_wr && reg_addr == tmon_pkg::ADDR_REMOTE_THERM
    |=> lim_q.remote_thermal_value == $past(reg_wdata))
    else $error("limit write not taken");

  a_limit_hold: assert property (
    !reg_wr |=> $stable(lim_q))
    else $error("limit changed without write");
endmodule
`default_nettype wire

/* verif/tmon_host.sv */
// Purpose: Register master standing in for the management bus host
// Assumes: Requests launched just after rising mclk, one at a time
// Notes: A read that sees no valid within four edges returns ok low
`default_nettype none
module tmon_host (
  input wire logic mclk,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // Stale data is inverted so a late sample cannot match by luck
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    ok = 1'b0;
    d = 8'hxx;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge mclk);
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the temperature bank and duty slew
// Assumes: Base tick shortened to 8 cycles
// Notes: Auto rate 4 and the slow speed monitor both update once per 64 cycles
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 8;
  logic mclk, reset_n, reg_rd, reg_wr, reg_rvalid, temp_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, target_duty, sw_duty, duty_cycle;
  logic [10:0] local_temp_reading, remote_temp_reading;
  logic [15:0] fan_period_count, fan_period_target;
  tmon_pkg::tmon_mode_t fan_mode;
  tmon_pkg::tmon_slew_cfg_t slew_cfg;
  tmon_pkg::tmon_limits_t limits;
  tmon_pkg::tmon_flags_t temp_flags;
  int error_cnt = 0;
  int checks_done = 0;

  tmon_regs_slew #(.TICK_CYCLES(TICK)) u_dut (.mclk, .reset_n, .reg_rd, .reg_wr, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .temp_valid, .local_temp_reading,
    .remote_temp_reading, .fan_mode, .slew_cfg, .target_duty, .sw_duty, .fan_period_count,
    .fan_period_target, .duty_cycle, .limits, .temp_flags);
  tmon_host u_host (.mclk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask
  task automatic chd(input logic [7:0] exp);
    chk(48'(duty_cycle), 48'(exp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    if (!ok) begin
      error_cnt++;
      summarize();
    end
    chk(48'(d), 48'(exp));
  endtask
  // Edges until duty_cycle next moves; bounded so a stuck slew ends the run
  task automatic gap(output int n);
    logic [7:0] v;
    v = duty_cycle;
    n = 0;
    while (duty_cycle === v) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 2000) begin
        error_cnt++;
        summarize();
      end
    end
  endtask
  task automatic mode(input tmon_pkg::tmon_mode_t m, input logic [8:0] c,
                      input logic [7:0] t, input logic [7:0] s, input logic [15:0] p);
    @(posedge mclk);
    fan_mode <= m;
    slew_cfg <= c;
    target_duty <= t;
    sw_duty <= s;
    fan_period_target <= p;
  endtask
  task automatic pulse(input logic [10:0] l, input logic [10:0] r);
    @(posedge mclk);
    temp_valid <= 1'b1;
    local_temp_reading <= l;
    remote_temp_reading <= r;
    @(posedge mclk);
    temp_valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic t_regs();
    logic [7:0] ad[10] = '{8'h06, 8'h0A, 8'h0B, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h07};
    logic [7:0] rv[10] = '{8'h00, 8'h80, 8'h80, 8'h3C, 8'h00, 8'h46, 8'h50, 8'h00, 8'h64, 8'h00};
    for (int i = 0; i < 10; i++) rd(ad[i], rv[i]);
    for (int i = 3; i < 9; i++) u_host.wr(ad[i], ad[i] ^ 8'hA5);
    u_host.wr(8'h0A, 8'h11);
    for (int i = 1; i < 9; i++) rd(ad[i], (i < 3) ? 8'h80 : ad[i] ^ 8'hA5);
    chk(limits, 48'hB1B0_B3BD_BCBF);
  endtask
  task automatic t_temp();
    pulse(11'h1F3, 11'h2C6);
    rd(8'h06, 8'h66);
    pulse(11'h100, 11'h7FD);
    rd(8'h0A, 8'h3E);
    rd(8'h0B, 8'h58);
    rd(8'h0A, 8'h20);
    rd(8'h0B, 8'hFF);
    rd(8'h06, 8'h05);
  endtask
  // Local reading stays 256; the upper bound moves across it, equality must not flag
  task automatic t_flags();
    u_host.wr(8'h14, 8'h20);
    pulse(11'h100, 11'h7FD);
    chk(48'(temp_flags), 48'h0000_0000_000D);
    u_host.wr(8'h14, 8'h1F);
    pulse(11'h100, 11'h7FD);
    chk(48'(temp_flags), 48'h0000_0000_002D);
  endtask
  task automatic t_auto();
    int n;
    mode(tmon_pkg::MODE_DCY, 9'h1FF, 8'h00, 8'h10, 16'h00F5);
    repeat (4) @(posedge mclk);
    chd(8'h10);
    mode(tmon_pkg::MODE_AUTO, 9'h138, 8'h30, 8'h10, 16'h00F5);
    gap(n);
    gap(n);
    chk(48'(n), 48'h0008);
    repeat (300) @(posedge mclk);
    chd(8'h2F);
    mode(tmon_pkg::MODE_AUTO, 9'h120, 8'h10, 8'h10, 16'h00F5);
    gap(n);
    gap(n);
    chk(48'(n), 48'h0040);
    mode(tmon_pkg::MODE_DCY, 9'h000, 8'h00, 8'h40, 16'h00F5);
    repeat (4) @(posedge mclk);
    mode(tmon_pkg::MODE_AUTO, 9'h1B8, 8'h35, 8'h40, 16'h00F5);
    repeat (60) @(posedge mclk);
    chd(8'h35);
    mode(tmon_pkg::MODE_AUTO, 9'h0B8, 8'h90, 8'h40, 16'h00F5);
    repeat (20) @(posedge mclk);
    chd(8'h90);
    mode(tmon_pkg::MODE_AUTO, 9'h0BE, 8'h94, 8'h40, 16'h00F5);
    repeat (40) @(posedge mclk);
    chd(8'h90);
    mode(tmon_pkg::MODE_AUTO, 9'h0BE, 8'h95, 8'h40, 16'h00F5);
    repeat (20) @(posedge mclk);
    chd(8'h95);
  endtask
  task automatic t_rpm();
    int n;
    logic [7:0] v;
    mode(tmon_pkg::MODE_RPM, 9'h047, 8'h00, 8'h00, 16'h00F5);
    gap(n);
    v = duty_cycle;
    gap(n);
    chk(48'(n), 48'h0008);
    chd(v + 8'h02);
    mode(tmon_pkg::MODE_RPM, 9'h046, 8'h00, 8'h00, 16'h00F5);
    gap(n);
    gap(n);
    chk(48'(n), 48'h0040);
    mode(tmon_pkg::MODE_RPM, 9'h046, 8'h00, 8'h00, 16'h00F6);
    repeat (2) @(posedge mclk);
    v = duty_cycle;
    repeat (150) @(posedge mclk);
    chd(v);
    // One unit of headroom left: the step must shrink to it, then stop at full scale
    mode(tmon_pkg::MODE_DCY, 9'h000, 8'h00, 8'hFE, 16'h00F5);
    repeat (4) @(posedge mclk);
    mode(tmon_pkg::MODE_RPM, 9'h047, 8'h00, 8'hFE, 16'h00F5);
    repeat (30) @(posedge mclk);
    chd(8'hFF);
    // Period shorter than target: the fan is too fast, duty steps down
    mode(tmon_pkg::MODE_RPM, 9'h047, 8'h00, 8'hFE, 16'h0110);
    gap(n);
    v = duty_cycle;
    gap(n);
    chd(v - 8'h02);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    reset_n = 1'b0;
    temp_valid = 1'b0;
    local_temp_reading = 11'h000;
    remote_temp_reading = 11'h000;
    fan_mode = tmon_pkg::MODE_DCY;
    slew_cfg = 9'h000;
    target_duty = 8'h00;
    sw_duty = 8'h00;
    fan_period_count = 16'h0100;
    fan_period_target = 16'h0100;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_temp();
    t_flags();
    t_auto();
    t_rpm();
    summarize();
  end
endmodule
`default_nettype wire
